// ===== bench/phy_mgmt_bitbang_ctrl_tb.sv
// Self-checking testbench of the PHY management register block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module phy_mgmt_bitbang_ctrl_tb;
    import phy_mgmt_pkg::*;
    logic              core_clk = 1'b0;
    logic              rst_n    = 1'b0;
    logic [ADDR_W-1:0] addr     = 4'h0;
    logic [DATA_W-1:0] wdata    = 16'h0000;
    logic              wr_s     = 1'b0;
    logic              rd_s     = 1'b0;
    logic              dpx = 1'b1, l10 = 1'b1, l100 = 1'b1, l1000 = 1'b1;
    logic              bv = 1'b0, last = 1'b0, vlan = 1'b0;
    logic              resp_en  = 1'b0;
    logic [7:0]        resp     = 8'h00;
    logic [DATA_W-1:0] rdata;
    logic              mdc, mdio_out, mdio_oe, duplex_full, st_v, ovf;
    logic              phy_oe, phy_out;
    logic [1:0]        speed;
    logic [7:0]        captured;
    wire               mdio_line;
    logic [15:0]       ctrl_m   = 16'h0000;
    int                lim_m    = 1514;
    int                bad_count = 0, num_checks = 0;
    logic              pend     = 1'b0;
    logic              expq[$];
    logic [15:0]       rnd      = 16'h558D;
    logic [15:0]       rd_val   = 16'h0000;
    logic [15:0]       vw       = 16'h0000;
    logic              exp_ovf  = 1'b0;

    // Pull-up holds the line high when nobody drives it
    assign mdio_line = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);
    always #2 core_clk = ~core_clk;

    phy_mgmt_bitbang_ctrl i_dut (.i_core_clk(core_clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
        .o_rdata(rdata), .o_mdc(mdc), .o_mdio_out(mdio_out),
        .o_mdio_oe(mdio_oe), .i_mdio_in(mdio_line),
        .i_phy_duplex_input(dpx), .i_phy_link_10_input(l10),
        .i_phy_link_100_input(l100), .i_phy_link_1000_input(l1000),
        .o_duplex_full(duplex_full), .o_link_speed_state(speed),
        .i_rx_byte_valid(bv), .i_rx_last(last), .i_rx_vlan(vlan),
        .o_rx_status_valid(st_v), .o_rx_oversize_flag(ovf));
    phy_model i_phy (.i_mdc(mdc), .i_line(mdio_line), .i_resp_en(resp_en),
        .i_resp(resp), .o_oe(phy_oe), .o_out(phy_out),
        .o_captured(captured));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Expected control register view from the stored bits and live pins
    function automatic logic [15:0] view();
        logic [1:0] sp;
        logic       md;
        sp = (l1000 == ctrl_m[5]) ? LINK_1000 : (l100 == ctrl_m[5]) ?
             LINK_100 : (l10 == ctrl_m[5]) ? LINK_10 : LINK_DOWN;
        md = ctrl_m[2] ? ctrl_m[1] : (phy_oe ? phy_out : 1'b1);
        view = {8'h00, sp, ctrl_m[5], dpx == ctrl_m[3], ctrl_m[3:2], md,
                ctrl_m[0]};
    endfunction : view

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge core_clk);
        wr_s  <= 1'b0;
        if (a == OFF_SIZE_LIMIT) lim_m = d & 16'h3FFF;
        else if (a == OFF_PHY_CTRL) ctrl_m = d & 16'h002F;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        logic [15:0] e;
        addr <= a;
        rd_s <= 1'b1;
        @(posedge core_clk);
        rd_s <= 1'b0;
        e = (a == OFF_SIZE_LIMIT) ? lim_m[15:0] :
            (a == OFF_PHY_CTRL) ? view() : 16'h0000;
        @(negedge core_clk);
        rd_val = rdata;
        `CHK("rdata", e, rdata)
        @(posedge core_clk);
    endtask : rd

    task automatic frame(input int n, input logic tag);
        for (int i = 0; i < n; i++) begin
            bv   <= 1'b1;
            last <= (i == n - 1);
            vlan <= tag;
            @(posedge core_clk);
        end
        expq.push_back(n >= lim_m + (tag ? 4 : 0));
        pend = 1'b1;
    endtask : frame

    // Host paces each management clock phase to 200 ns
    task automatic mstep(input logic [15:0] v);
        wr(OFF_PHY_CTRL, v);
        repeat (49) @(posedge core_clk);
    endtask : mstep

    always @(negedge core_clk) begin
        if (rst_n) begin
            `CHK("rx_status_valid", pend, st_v)
            if (pend) begin
                exp_ovf = expq.pop_front();
                `CHK("rx_oversize", exp_ovf, ovf)
            end
            pend = 1'b0;
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    initial begin
        repeat (100000) @(posedge core_clk);
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(OFF_SIZE_LIMIT);
        rd(OFF_PHY_CTRL);
        frame(1513, 1'b0);
        frame(1518, 1'b1);
        bv <= 1'b0;
        last <= 1'b0;
        @(posedge core_clk);
        wr(OFF_SIZE_LIMIT, 16'hFFFF);
        rd(OFF_SIZE_LIMIT);
        wr(4'h5, 16'hFFFF);
        rd(4'h5);
        wr(OFF_SIZE_LIMIT, 16'h000A);
        frame(9, 1'b0);
        frame(10, 1'b0);
        frame(13, 1'b1);
        frame(14, 1'b1);
        frame(1, 1'b0);
        bv <= 1'b0;
        @(posedge core_clk);
        last <= 1'b0;
        @(posedge core_clk);
        for (int k = 0; k < 24; k++) begin
            rnd = lfsr(rnd);
            {resp_en, l1000, l100, l10, dpx} <= rnd[12:8];
            resp <= rnd[7:0];
            wr(OFF_PHY_CTRL, rnd);
            rd(OFF_PHY_CTRL);
            `CHK("mdc", ctrl_m[0], mdc)
            `CHK("mdio_out", ctrl_m[1], mdio_out)
            `CHK("mdio_oe", ctrl_m[2], mdio_oe)
            vw = view();
            `CHK("duplex", vw[4], duplex_full)
            `CHK("speed", vw[7:6], speed)
        end
        resp_en <= 1'b0;
        rnd = lfsr(rnd);
        for (int k = 7; k >= 0; k--) begin
            mstep({13'h0000, 1'b1, rnd[k], 1'b0});
            mstep({13'h0000, 1'b1, rnd[k], 1'b1});
        end
        `CHK("phy_captured", rnd[7:0], captured)
        resp    <= rnd[15:8];
        resp_en <= 1'b1;
        for (int k = 7; k >= 0; k--) begin
            mstep(16'h0000);
            rd(OFF_PHY_CTRL);
            `CHK("mdio_in_bit", rnd[8 + k], rd_val[1])
            mstep(16'h0001);
        end
        // Second reset in mid-run brings back the reset values
        rst_n  <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n  <= 1'b1;
        lim_m   = 1514;
        ctrl_m  = 16'h0000;
        @(posedge core_clk);
        rd(OFF_SIZE_LIMIT);
        rd(OFF_PHY_CTRL);
        stop_test();
    end
endmodule : phy_mgmt_bitbang_ctrl_tb

// ===== bench/phy_model.sv
// Far side model: PHY on the shared management clock and data lines
`timescale 1ns/100ps
module phy_model (
    input  wire logic       i_mdc,
    input  wire logic       i_line,
    input  wire logic       i_resp_en,
    input  wire logic [7:0] i_resp,
    output logic            o_oe,
    output logic            o_out,
    output logic [7:0]      o_captured
);
    logic [2:0] idx = 3'h0;
    initial o_captured = 8'h00;
    // Samples the line on each rising management clock
    always @(posedge i_mdc) begin
        o_captured <= {o_captured[6:0], i_line};
        idx        <= i_resp_en ? idx + 3'h1 : 3'h0;
    end
    // Drives response bits msb first whenever the response enable is set
    assign o_oe  = i_resp_en;
    assign o_out = i_resp[3'h7 - idx];
endmodule : phy_model

// ===== hdl/phy_mgmt_bitbang_ctrl.sv
// Frame size limit and bit-banged PHY management register block
`timescale 1ns/100ps
//
// Functional notes
// - Count frame bytes address to data end; flag at or above limit.
// - Tagged frames compare against limit plus four bytes.
// - Control bit 0 drives the management clock output directly.
// - Direction 1: written data bit is driven onto the data line.
// - Direction 0: line released; data bit reads the PHY level.
// - Direction control is bit 2; setting it makes the device drive.
// - Bit 3 picks duplex input polarity; 0 active low, 1 active high.
// - Bit 4 reads live adjusted duplex; 1 means full duplex.
// - Bit 5 sets polarity of the three link inputs; 0 active low.
// - Same clock and data lines reach external PHY and internal PCS.
// - Reserved size bits ignored on write; software writes them as zero.
module phy_mgmt_bitbang_ctrl
    import phy_mgmt_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_mdc,
    output logic                   o_mdio_out,
    output logic                   o_mdio_oe,
    input  wire logic              i_mdio_in,
    input  wire logic              i_phy_duplex_input,
    input  wire logic              i_phy_link_10_input,
    input  wire logic              i_phy_link_100_input,
    input  wire logic              i_phy_link_1000_input,
    output logic                   o_duplex_full,
    output logic      [1:0]        o_link_speed_state,
    input  wire logic              i_rx_byte_valid,
    input  wire logic              i_rx_last,
    input  wire logic              i_rx_vlan,
    output logic                   o_rx_status_valid,
    output logic                   o_rx_oversize_flag
);
    logic [SIZE_W-1:0] size_limit;
    logic [SIZE_W-1:0] next_size_limit;
    logic              mgmt_clock_bit;
    logic              next_mgmt_clock_bit;
    logic              mgmt_data_bit;
    logic              next_mgmt_data_bit;
    logic              mgmt_direction_bit;
    logic              next_mgmt_direction_bit;
    logic              duplex_input_polarity;
    logic              next_duplex_input_polarity;
    logic              link_input_polarity;
    logic              next_link_input_polarity;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic              duplex_full;
    logic              next_duplex_full;
    logic [1:0]        link_speed;
    logic [1:0]        next_link_speed;
    logic              duplex_live_status;
    logic              link_10_up;
    logic              link_100_up;
    logic              link_1000_up;
    logic [1:0]        link_speed_state;
    logic [CTRL_W-1:0] ctrl_view;
    logic              wr_size;
    logic              wr_ctrl;

    rx_len_if rx ();

    rx_oversize_checker u_checker (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .rx         (rx.chk)
    );

    assign rx.limit      = size_limit;
    assign rx.byte_valid = i_rx_byte_valid;
    assign rx.last       = i_rx_last;
    assign rx.vlan       = i_rx_vlan;

    // Polarity adjust of the PHY status inputs
    pin_polarity u_pol_duplex (
        .i_pin         (i_phy_duplex_input),
        .i_active_high (duplex_input_polarity),
        .o_active      (duplex_live_status)
    );
    pin_polarity u_pol_link10 (
        .i_pin         (i_phy_link_10_input),
        .i_active_high (link_input_polarity),
        .o_active      (link_10_up)
    );
    pin_polarity u_pol_link100 (
        .i_pin         (i_phy_link_100_input),
        .i_active_high (link_input_polarity),
        .o_active      (link_100_up)
    );
    pin_polarity u_pol_link1000 (
        .i_pin         (i_phy_link_1000_input),
        .i_active_high (link_input_polarity),
        .o_active      (link_1000_up)
    );

    // Fastest active link wins if the PHY shows more than one
    always_comb begin
        if (link_1000_up) begin
            link_speed_state = LINK_1000;
        end else if (link_100_up) begin
            link_speed_state = LINK_100;
        end else if (link_10_up) begin
            link_speed_state = LINK_10;
        end else begin
            link_speed_state = LINK_DOWN;
        end
    end

    // Live view of the PHY control register
    always_comb begin
        ctrl_view                  = {CTRL_W{1'b0}};
        ctrl_view[MGMT_CLK_BIT]    = mgmt_clock_bit;
        ctrl_view[MGMT_DATA_BIT]   = mgmt_direction_bit
                                     ? mgmt_data_bit
                                     : i_mdio_in;
        ctrl_view[MGMT_DIR_BIT]    = mgmt_direction_bit;
        ctrl_view[DUPLEX_POL_BIT]  = duplex_input_polarity;
        ctrl_view[DUPLEX_STAT_BIT] = duplex_live_status;
        ctrl_view[LINK_POL_BIT]    = link_input_polarity;
        ctrl_view[LINK_SPEED_HI:LINK_SPEED_LO] = link_speed_state;
    end

    assign wr_size = i_wr && (i_addr == OFF_SIZE_LIMIT);
    assign wr_ctrl = i_wr && (i_addr == OFF_PHY_CTRL);

    always_comb begin
        next_size_limit            = size_limit;
        next_mgmt_clock_bit        = mgmt_clock_bit;
        next_mgmt_data_bit         = mgmt_data_bit;
        next_mgmt_direction_bit    = mgmt_direction_bit;
        next_duplex_input_polarity = duplex_input_polarity;
        next_link_input_polarity   = link_input_polarity;
        next_rdata                 = {DATA_W{1'b0}};
        next_duplex_full           = duplex_live_status;
        next_link_speed            = link_speed_state;
        if (wr_size) begin
            next_size_limit = i_wdata[SIZE_W-1:0];
        end
        if (wr_ctrl) begin
            next_mgmt_clock_bit        = i_wdata[MGMT_CLK_BIT];
            next_mgmt_data_bit         = i_wdata[MGMT_DATA_BIT];
            next_mgmt_direction_bit    = i_wdata[MGMT_DIR_BIT];
            next_duplex_input_polarity = i_wdata[DUPLEX_POL_BIT];
            next_link_input_polarity   = i_wdata[LINK_POL_BIT];
        end
        if (i_rd) begin
            case (i_addr)
                OFF_SIZE_LIMIT: begin
                    next_rdata = {2'h0, size_limit};
                end
                OFF_PHY_CTRL: begin
                    next_rdata = {8'h00, ctrl_view};
                end
                default: begin
                    next_rdata = {DATA_W{1'b0}};
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            size_limit            <= SIZE_LIMIT_RESET;
            mgmt_clock_bit        <= CTRL_BIT_RESET;
            mgmt_data_bit         <= CTRL_BIT_RESET;
            mgmt_direction_bit    <= CTRL_BIT_RESET;
            duplex_input_polarity <= CTRL_BIT_RESET;
            link_input_polarity   <= CTRL_BIT_RESET;
            rdata                 <= {DATA_W{1'b0}};
            duplex_full           <= 1'b0;
            link_speed            <= LINK_DOWN;
        end else begin
            size_limit            <= next_size_limit;
            mgmt_clock_bit        <= next_mgmt_clock_bit;
            mgmt_data_bit         <= next_mgmt_data_bit;
            mgmt_direction_bit    <= next_mgmt_direction_bit;
            duplex_input_polarity <= next_duplex_input_polarity;
            link_input_polarity   <= next_link_input_polarity;
            rdata                 <= next_rdata;
            duplex_full           <= next_duplex_full;
            link_speed            <= next_link_speed;
        end
    end

    // One clock and data pair serves the external PHY and internal PCS
    assign o_mdc              = mgmt_clock_bit;
    assign o_mdio_out         = mgmt_data_bit;
    assign o_mdio_oe          = mgmt_direction_bit;
    assign o_rdata            = rdata;
    assign o_duplex_full      = duplex_full;
    assign o_link_speed_state = link_speed;
    assign o_rx_status_valid  = rx.status_valid;
    assign o_rx_oversize_flag = rx.oversize;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_mdc_follows_write;
        wr_ctrl |=> (o_mdc == $past(i_wdata[MGMT_CLK_BIT]));
    endproperty
    a_mdc_follows_write: assert property (p_mdc_follows_write)
        else $error("Management clock does not follow written bit");

    property p_drive_data;
        (wr_ctrl && i_wdata[MGMT_DIR_BIT])
        |=> (o_mdio_oe && o_mdio_out == $past(i_wdata[MGMT_DATA_BIT]));
    endproperty
    a_drive_data: assert property (p_drive_data)
        else $error("Written data bit not driven on the line");

    property p_release_line;
        (wr_ctrl && !i_wdata[MGMT_DIR_BIT]) |=> !o_mdio_oe;
    endproperty
    a_release_line: assert property (p_release_line)
        else $error("Data line not released with direction 0");

    property p_read_phy_level;
        (i_rd && i_addr == OFF_PHY_CTRL && !o_mdio_oe)
        |=> (o_rdata[MGMT_DATA_BIT] == $past(i_mdio_in));
    endproperty
    a_read_phy_level: assert property (p_read_phy_level)
        else $error("Data bit read does not show the PHY level");

    property p_read_own_level;
        (i_rd && i_addr == OFF_PHY_CTRL && o_mdio_oe)
        |=> (o_rdata[MGMT_DATA_BIT] == $past(o_mdio_out));
    endproperty
    a_read_own_level: assert property (p_read_own_level)
        else $error("Data bit read does not show the driven value");

    property p_duplex_status;
        (i_rd && i_addr == OFF_PHY_CTRL)
        |=> (o_rdata[DUPLEX_STAT_BIT] ==
             ($past(i_phy_duplex_input) ~^ $past(duplex_input_polarity)));
    endproperty
    a_duplex_status: assert property (p_duplex_status)
        else $error("Duplex status does not match adjusted input");

    property p_link_down;
        (i_rd && i_addr == OFF_PHY_CTRL &&
         (i_phy_link_10_input ~^ link_input_polarity) == 1'b0 &&
         (i_phy_link_100_input ~^ link_input_polarity) == 1'b0 &&
         (i_phy_link_1000_input ~^ link_input_polarity) == 1'b0)
        |=> (o_rdata[LINK_SPEED_HI:LINK_SPEED_LO] == LINK_DOWN);
    endproperty
    a_link_down: assert property (p_link_down)
        else $error("Link shown up with no active link input");

    property p_size_readback;
        (wr_size ##1 (i_rd && i_addr == OFF_SIZE_LIMIT && !i_wr))
        |=> (o_rdata == {2'h0, $past(i_wdata[SIZE_W-1:0], 2)});
    endproperty
    a_size_readback: assert property (p_size_readback)
        else $error("Size limit read back wrong or reserved bits set");

    // Status outputs follow the adjusted pins one cycle later
    property p_duplex_output;
        1'b1 |=> (o_duplex_full == ($past(i_phy_duplex_input) ~^
                                    $past(duplex_input_polarity)));
    endproperty
    a_duplex_output: assert property (p_duplex_output)
        else $error("Duplex output does not follow adjusted input");

    property p_link_gigabit;
        (i_phy_link_1000_input ~^ link_input_polarity)
        |=> (o_link_speed_state == LINK_1000);
    endproperty
    a_link_gigabit: assert property (p_link_gigabit)
        else $error("Active gigabit link input not shown as 1000");

    property p_link_fast;
        ((i_phy_link_100_input ~^ link_input_polarity) &&
         !(i_phy_link_1000_input ~^ link_input_polarity))
        |=> (o_link_speed_state == LINK_100);
    endproperty
    a_link_fast: assert property (p_link_fast)
        else $error("Active 100 link input not shown as 100");

    property p_link_slow;
        ((i_phy_link_10_input ~^ link_input_polarity) &&
         !(i_phy_link_100_input ~^ link_input_polarity) &&
         !(i_phy_link_1000_input ~^ link_input_polarity))
        |=> (o_link_speed_state == LINK_10);
    endproperty
    a_link_slow: assert property (p_link_slow)
        else $error("Lone 10 link input not shown as 10");

    property p_dir_readback;
        (i_rd && i_addr == OFF_PHY_CTRL)
        |=> (o_rdata[MGMT_DIR_BIT] == $past(o_mdio_oe));
    endproperty
    a_dir_readback: assert property (p_dir_readback)
        else $error("Direction bit read does not match line drive");

    property p_size_reserved;
        (i_rd && i_addr == OFF_SIZE_LIMIT)
        |=> (o_rdata[DATA_W-1:SIZE_W] == 2'h0);
    endproperty
    a_size_reserved: assert property (p_size_reserved)
        else $error("Reserved size limit bits read as nonzero");

    c_mdio_turnaround: cover property (
        wr_ctrl && !i_wdata[MGMT_DIR_BIT] && o_mdio_oe);
    c_read_phy_bit: cover property (
        i_rd && i_addr == OFF_PHY_CTRL && !o_mdio_oe && i_mdio_in);
    c_gigabit_link: cover property (link_speed_state == LINK_1000);
endmodule : phy_mgmt_bitbang_ctrl

// ===== hdl/phy_mgmt_pkg.sv
// Package of constants and types for the PHY management and frame size block
package phy_mgmt_pkg;
    localparam int          ADDR_W           = 4;
    localparam int          DATA_W           = 16;
    localparam int          SIZE_W           = 14;
    localparam int          CNT_W            = 16;
    localparam int          CTRL_W           = 8;
    localparam logic [3:0]  OFF_SIZE_LIMIT   = 4'h0;
    localparam logic [3:0]  OFF_PHY_CTRL     = 4'h1;
    localparam logic [13:0] SIZE_LIMIT_RESET = 14'h05EA;
    localparam logic [15:0] VLAN_EXTRA       = 16'h0004;
    localparam int          MGMT_CLK_BIT     = 0;
    localparam int          MGMT_DATA_BIT    = 1;
    localparam int          MGMT_DIR_BIT     = 2;
    localparam int          DUPLEX_POL_BIT   = 3;
    localparam int          DUPLEX_STAT_BIT  = 4;
    localparam int          LINK_POL_BIT     = 5;
    localparam int          LINK_SPEED_LO    = 6;
    localparam int          LINK_SPEED_HI    = 7;
    localparam logic [1:0]  LINK_DOWN        = 2'h0;
    localparam logic [1:0]  LINK_10          = 2'h1;
    localparam logic [1:0]  LINK_100         = 2'h2;
    localparam logic [1:0]  LINK_1000        = 2'h3;
    localparam logic        CTRL_BIT_RESET   = 1'b0;
    localparam logic [15:0] CNT_RESET        = 16'h0000;
    localparam logic [15:0] CNT_MAX          = 16'hFFFF;
endpackage : phy_mgmt_pkg

// ===== hdl/pin_polarity.sv
// Polarity adjust of one PHY status input
`timescale 1ns/100ps
module pin_polarity (
    input  wire logic i_pin,
    input  wire logic i_active_high,
    output logic      o_active
);
    // A 0 selects active low, a 1 active high
    assign o_active = i_active_high ? i_pin : ~i_pin;
endmodule : pin_polarity

// ===== hdl/rx_len_if.sv
// Interface between the register block and the frame length checker
`timescale 1ns/100ps
interface rx_len_if;
    import phy_mgmt_pkg::*;
    logic [SIZE_W-1:0] limit;
    logic              byte_valid;
    logic              last;
    logic              vlan;
    logic              status_valid;
    logic              oversize;
    modport regs    (output limit, byte_valid, last, vlan,
                     input  status_valid, oversize);
    modport chk     (input  limit, byte_valid, last, vlan,
                     output status_valid, oversize);
endinterface : rx_len_if

// ===== hdl/rx_oversize_checker.sv
// Counts received frame bytes and flags frames at or above the size limit, or the limit plus four bytes for tagged frames
`timescale 1ns/100ps
module rx_oversize_checker
    import phy_mgmt_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    rx_len_if.chk     rx
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             status_valid;
    logic             next_status_valid;
    logic             oversize;
    logic             next_oversize;
    logic [CNT_W-1:0] count_now;
    logic [CNT_W-1:0] threshold;

    always_comb begin
        count_now = (count == CNT_MAX) ? count : count + 16'h0001;
        threshold = {2'h0, rx.limit} +
                    (rx.vlan ? VLAN_EXTRA : 16'h0000);
        next_count        = count;
        next_status_valid = 1'b0;
        next_oversize     = oversize;
        if (rx.byte_valid) begin
            next_count = count_now;
            if (rx.last) begin
                next_count        = CNT_RESET;
                next_status_valid = 1'b1;
                next_oversize     = (count_now >= threshold);
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count        <= CNT_RESET;
            status_valid <= 1'b0;
            oversize     <= 1'b0;
        end else begin
            count        <= next_count;
            status_valid <= next_status_valid;
            oversize     <= next_oversize;
        end
    end

    assign rx.status_valid = status_valid;
    assign rx.oversize     = oversize;

    property p_flag_at_limit;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (rx.byte_valid && rx.last && !rx.vlan &&
         count_now == {2'h0, rx.limit})
        |=> (status_valid && oversize);
    endproperty
    a_flag_at_limit: assert property (p_flag_at_limit)
        else $error("Frame at the limit not flagged");

    property p_vlan_allowance;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (rx.byte_valid && rx.last && rx.vlan &&
         count_now == {2'h0, rx.limit} + 16'h0003)
        |=> (status_valid && !oversize);
    endproperty
    a_vlan_allowance: assert property (p_vlan_allowance)
        else $error("Tagged frame below limit plus four flagged");

    c_oversize_frame: cover property (@(posedge i_core_clk)
        status_valid && oversize);
    c_tagged_frame: cover property (@(posedge i_core_clk)
        rx.byte_valid && rx.last && rx.vlan);
endmodule : rx_oversize_checker
